//--- hw/acs_sequencer.sv
`timescale 1ns/1ps
module acs_sequencer
	import acs_pkg::*;
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	// converter core
	output logic                   core_clk_en,
	output logic                   core_power_en,
	output logic                   core_cal_req,
	input  wire logic              core_cal_done,
	output logic                   core_conv_req,
	output logic      [CH_W-1:0]   core_channel,
	input  wire logic              core_conv_done,
	input  wire logic [RES_W-1:0]  core_result,
	// interrupt
	output logic                   conv_done_int
);

	// ==========================================================
	// registers
	logic                         conv_enable_q;
	logic                         conv_start_q;
	logic                         continuous_loop_q;
	logic                         result_freeze_q;
	logic                         conv_done_mask_q;
	logic [IDX_W-1:0]             stop_slot_index_q;
	logic [DLY_W-1:0]             pre_sequence_delay_q;
	logic [DLY_W-1:0]             inter_conversion_delay_q;
	logic [DLY_W-1:0]             post_sequence_delay_q;
	logic [SLOTS-1:0][CH_W-1:0]   slot_channel_select_q;
	logic [SLOTS-1:0][RES_W-1:0]  slot_result_q;
	logic                         conv_done_irq_q;
	logic                         cal_done_q;
	acs_state_e                   state_q;
	logic [IDX_W-1:0]             slot_q;

	logic                         tick;
	logic                         tmr_load;
	logic [TMR_W-1:0]             tmr_val;
	logic                         tmr_expired;
	logic                         conv_got;
	logic                         seq_last;
	logic                         seq_finish;
	logic                         launch;
	logic                         ctrl_wr;
	logic                         res_update;
	logic [DATA_W/2-1:0]          res_word [4];

	function automatic logic [TMR_W-1:0] dly_ticks(input logic [DLY_W-1:0] code);
		dly_ticks = TMR_W'(int'(code) * STEP_TICKS);
	endfunction

	function automatic logic [CH_W-1:0] chan_of(
		input logic [SLOTS-1:0][CH_W-1:0] sel,
		input logic [IDX_W-1:0]           idx);
		chan_of = sel[idx];
	endfunction

	// ==========================================================
	// rate divider and delay timer
	acs_tick_div u_div (
		.clk     (clk),
		.sys_rst (sys_rst),
		.tick    (tick)
	);

	acs_delay_timer u_tmr (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.tick     (tick),
		.load     (tmr_load),
		.load_val (tmr_val),
		.expired  (tmr_expired)
	);

	assign core_clk_en   = tick;
	assign core_power_en = conv_enable_q;
	assign core_cal_req  = (state_q == ST_CAL);
	assign core_channel  = chan_of(slot_channel_select_q, slot_q);
	// reserved channel has no source: skip the core and store zero
	assign core_conv_req = (state_q == ST_CONV) && conv_enable_q
		&& (core_channel != CHAN_RESERVED);
	assign conv_got   = tick && (state_q == ST_CONV)
		&& (core_conv_done || core_channel == CHAN_RESERVED);
	assign seq_last   = (slot_q == stop_slot_index_q);
	assign seq_finish = conv_got && seq_last && conv_enable_q;
	assign launch     = tick && (state_q == ST_IDLE) && conv_enable_q && conv_start_q;
	assign ctrl_wr    = reg_wr && (reg_addr == REG_CTRL);
	// freeze only bites in continuous mode and never stalls the core
	assign res_update = conv_got && conv_enable_q
		&& !(result_freeze_q && continuous_loop_q);

	// ==========================================================
	// timer load on entry to each waiting state
	always_comb begin
		tmr_load = 1'b0;
		tmr_val  = '0;
		if (launch) begin
			tmr_load = 1'b1;
			tmr_val  = TMR_W'(SYNC_TICKS);
		end else if (tick && state_q == ST_SYNC && tmr_expired) begin
			tmr_load = 1'b1;
			tmr_val  = dly_ticks(pre_sequence_delay_q);
		end else if (conv_got && !seq_last) begin
			tmr_load = 1'b1;
			tmr_val  = dly_ticks(inter_conversion_delay_q);
		end else if (seq_finish && continuous_loop_q) begin
			tmr_load = 1'b1;
			tmr_val  = dly_ticks(post_sequence_delay_q);
		end
	end

	// ==========================================================
	// sequencer state
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= ST_CAL;
			slot_q  <= '0;
		end else if (tick) begin
			case (state_q)
				ST_CAL: begin
					if (core_cal_done) begin
						state_q <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (launch) begin
						state_q <= ST_SYNC;
						slot_q  <= '0;
					end
				end
				ST_SYNC: begin
					if (!conv_enable_q) begin
						state_q <= ST_IDLE;
					end else if (tmr_expired) begin
						state_q <= ST_DLY1;
					end
				end
				ST_DLY1, ST_DLY2: begin
					if (!conv_enable_q) begin
						state_q <= ST_IDLE;
					end else if (tmr_expired) begin
						state_q <= ST_CONV;
					end
				end
				ST_CONV: begin
					if (!conv_enable_q) begin
						state_q <= ST_IDLE;
					end else if (conv_got && !seq_last) begin
						state_q <= ST_DLY2;
						slot_q  <= slot_q + 1'b1;
					end else if (conv_got) begin
						state_q <= continuous_loop_q ? ST_DLY3 : ST_IDLE;
					end
				end
				ST_DLY3: begin
					if (!conv_enable_q || !continuous_loop_q) begin
						state_q <= ST_IDLE;
					end else if (tmr_expired) begin
						state_q <= ST_CONV;
						slot_q  <= '0;
					end
				end
				default: begin
					state_q <= ST_IDLE;
					slot_q  <= '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cal_done_q <= 1'b0;
		end else if (tick && state_q == ST_CAL && core_cal_done) begin
			cal_done_q <= 1'b1;
		end
	end

	// ==========================================================
	// results
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			slot_result_q <= {SLOTS{RES_RST}};
		end else if (res_update) begin
			// raw code kept as is, so current readings stay two's complement
			slot_result_q[slot_q] <= (core_channel == CHAN_RESERVED) ? RES_RST
				: core_result;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_res
			assign res_word[gi] = {6'h00, slot_result_q[2*gi]};
		end
	endgenerate

	// ==========================================================
	// done flag: set wins over the write-one clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			conv_done_irq_q <= 1'b0;
		end else if (seq_finish) begin
			conv_done_irq_q <= 1'b1;
		end else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[STAT_DONE_BIT]) begin
			conv_done_irq_q <= 1'b0;
		end
	end

	assign conv_done_int = conv_done_irq_q && !conv_done_mask_q;

	// ==========================================================
	// control register writes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			conv_enable_q     <= 1'b0;
			continuous_loop_q <= 1'b0;
			result_freeze_q   <= 1'b0;
			conv_done_mask_q  <= 1'b0;
			stop_slot_index_q <= STOP_RST;
		end else if (ctrl_wr) begin
			conv_enable_q     <= reg_wdata[CTRL_EN_BIT];
			continuous_loop_q <= reg_wdata[CTRL_CONT_BIT];
			result_freeze_q   <= reg_wdata[CTRL_FREEZE_BIT];
			conv_done_mask_q  <= reg_wdata[CTRL_MASK_BIT];
			stop_slot_index_q <= reg_wdata[CTRL_STOP_LSB +: IDX_W];
		end
	end

	// a fresh start written in the launch cycle is kept, not lost
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			conv_start_q <= 1'b0;
		end else if (ctrl_wr && reg_wdata[CTRL_START_BIT]) begin
			conv_start_q <= 1'b1;
		end else if (launch) begin
			conv_start_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pre_sequence_delay_q     <= DLY_RST;
			inter_conversion_delay_q <= DLY_RST;
			post_sequence_delay_q    <= DLY_RST;
		end else if (reg_wr && reg_addr == REG_DELAY) begin
			pre_sequence_delay_q     <= reg_wdata[DLY_PRE_LSB +: DLY_W];
			inter_conversion_delay_q <= reg_wdata[DLY_INTER_LSB +: DLY_W];
			post_sequence_delay_q    <= reg_wdata[DLY_POST_LSB +: DLY_W];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			slot_channel_select_q <= {SEL_RST, SEL_RST};
		end else if (reg_wr && reg_addr == REG_SEL_LO) begin
			slot_channel_select_q[3:0] <= reg_wdata[15:0];
		end else if (reg_wr && reg_addr == REG_SEL_HI) begin
			slot_channel_select_q[7:4] <= reg_wdata[15:0];
		end
	end

	// ==========================================================
	// read port: data only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (sys_rst || !reg_rd) begin
			reg_rdata <= '0;
		end else begin
			case (reg_addr)
				REG_CTRL: reg_rdata <= {24'h000000, stop_slot_index_q, conv_done_mask_q,
					result_freeze_q, continuous_loop_q, conv_start_q, conv_enable_q};
				REG_DELAY: reg_rdata <= {20'h00000, post_sequence_delay_q,
					inter_conversion_delay_q, pre_sequence_delay_q};
				REG_SEL_LO: reg_rdata <= {16'h0000, slot_channel_select_q[3:0]};
				REG_SEL_HI: reg_rdata <= {16'h0000, slot_channel_select_q[7:4]};
				REG_STATUS: reg_rdata <= {29'h00000000, cal_done_q,
					(state_q != ST_IDLE && state_q != ST_CAL), conv_done_irq_q};
				REG_RESULT0: reg_rdata <= {6'h00, slot_result_q[1], res_word[0]};
				REG_RESULT1: reg_rdata <= {6'h00, slot_result_q[3], res_word[1]};
				REG_RESULT2: reg_rdata <= {6'h00, slot_result_q[5], res_word[2]};
				REG_RESULT3: reg_rdata <= {6'h00, slot_result_q[7], res_word[3]};
				default: reg_rdata <= '0;
			endcase
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	irq_mask_gate_a: assert property (conv_done_int |-> conv_done_irq_q && !conv_done_mask_q
		&& $past(conv_done_mask_q) == conv_done_mask_q || !$stable(conv_done_mask_q))
		else $error("interrupt passed while masked");
	start_self_clear_a: assert property (launch && !ctrl_wr |=> !conv_start_q
		&& state_q == ST_SYNC) else $error("start bit not cleared on launch");
	seq_done_flag_a: assert property (seq_finish |=> conv_done_irq_q)
		else $error("done flag missing after sequence");
	abort_no_flag_a: assert property (tick && !conv_enable_q && state_q inside
		{ST_SYNC, ST_DLY1, ST_DLY2, ST_CONV} |=> state_q == ST_IDLE && !$rose(conv_done_irq_q))
		else $error("disable did not abort cleanly");
	single_stop_a: assert property (seq_finish && !continuous_loop_q |=> state_q == ST_IDLE)
		else $error("single sequence did not stop");
	loop_restart_a: assert property (tick && state_q == ST_DLY3 && tmr_expired
		&& conv_enable_q && continuous_loop_q |=> state_q == ST_CONV && slot_q == '0)
		else $error("loop did not restart at slot 0");
	freeze_hold_a: assert property (result_freeze_q && continuous_loop_q && !ctrl_wr
		|=> $stable(slot_result_q)) else $error("results changed while frozen");
	reserved_skip_a: assert property (state_q == ST_CONV && core_channel == CHAN_RESERVED
		|-> !core_conv_req) else $error("reserved channel sent to core");
	slot_bound_a: assert property (tick && state_q == ST_CONV && conv_got && seq_last
		|=> slot_q == $past(slot_q)) else $error("slot stepped past stop index");
	sync_wait_a: assert property (launch |=> (state_q == ST_SYNC) [*2])
		else $error("sync wait cut short");
	disabled_quiet_a: assert property (!conv_enable_q |-> !core_conv_req && !core_power_en)
		else $error("converter active while disabled");

	single_seq_c: cover property (seq_finish && !continuous_loop_q);
	loop_seq_c:   cover property (state_q == ST_DLY3 ##1 state_q == ST_CONV);
	abort_c:      cover property (state_q == ST_CONV ##1 state_q == ST_IDLE && !conv_enable_q);
	freeze_c:     cover property (conv_got && result_freeze_q && continuous_loop_q);

endmodule

//--- hw/acs_pkg.sv
package acs_pkg;

	// ==========================================================
	// clocking and derived step counts
	localparam int CLK_PERIOD_NS = 20;
	localparam int ADC_DIV       = 38;
	localparam int TICK_NS       = CLK_PERIOD_NS * ADC_DIV;
	localparam int SYNC_US       = 30;
	localparam int STEP_US       = 40;
	// sync is a longest time: round down, at least one tick
	localparam int SYNC_TICKS_RAW = (SYNC_US * 1000) / TICK_NS;
	localparam int SYNC_TICKS     = (SYNC_TICKS_RAW < 1) ? 1 : SYNC_TICKS_RAW;
	// delay step is a least time: round up
	localparam int STEP_TICKS     = (STEP_US * 1000 + TICK_NS - 1) / TICK_NS;

	// ==========================================================
	// widths
	localparam int RES_W  = 10;
	localparam int CH_W   = 4;
	localparam int SLOTS  = 8;
	localparam int IDX_W  = 3;
	localparam int DLY_W  = 4;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int TMR_W  = 10;
	localparam int DIV_W  = 6;

	// ==========================================================
	// register word offsets
	localparam logic [ADDR_W-1:0] REG_CTRL    = 4'h0;
	localparam logic [ADDR_W-1:0] REG_DELAY   = 4'h1;
	localparam logic [ADDR_W-1:0] REG_SEL_LO  = 4'h2;
	localparam logic [ADDR_W-1:0] REG_SEL_HI  = 4'h3;
	localparam logic [ADDR_W-1:0] REG_STATUS  = 4'h4;
	localparam logic [ADDR_W-1:0] REG_RESULT0 = 4'h5;
	localparam logic [ADDR_W-1:0] REG_RESULT1 = 4'h6;
	localparam logic [ADDR_W-1:0] REG_RESULT2 = 4'h7;
	localparam logic [ADDR_W-1:0] REG_RESULT3 = 4'h8;

	// control field positions
	localparam int CTRL_EN_BIT     = 0;
	localparam int CTRL_START_BIT  = 1;
	localparam int CTRL_CONT_BIT   = 2;
	localparam int CTRL_FREEZE_BIT = 3;
	localparam int CTRL_MASK_BIT   = 4;
	localparam int CTRL_STOP_LSB   = 5;
	// delay field positions
	localparam int DLY_PRE_LSB   = 0;
	localparam int DLY_INTER_LSB = 4;
	localparam int DLY_POST_LSB  = 8;
	// status field positions
	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_CAL_BIT  = 2;
	// result packing: two slots per word
	localparam int RES_HI_LSB = 16;

	// ==========================================================
	// reset values
	localparam logic [DLY_W-1:0] DLY_RST  = 4'h0;
	localparam logic [IDX_W-1:0] STOP_RST = 3'h0;
	localparam logic [15:0]      SEL_RST  = 16'h0000;
	localparam logic [RES_W-1:0] RES_RST  = 10'h000;

	localparam logic [CH_W-1:0] CHAN_RESERVED = 4'h6;

	typedef enum logic [6:0] {
		ST_CAL  = 7'b0000001,
		ST_IDLE = 7'b0000010,
		ST_SYNC = 7'b0000100,
		ST_DLY1 = 7'b0001000,
		ST_CONV = 7'b0010000,
		ST_DLY2 = 7'b0100000,
		ST_DLY3 = 7'b1000000
	} acs_state_e;

endpackage

//--- hw/acs_tick_div.sv
`timescale 1ns/1ps
module acs_tick_div
	import acs_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// enable pulse
	output logic      tick
);

	logic [DIV_W-1:0] cnt_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end else if (cnt_q == DIV_W'(ADC_DIV - 1)) begin
			cnt_q <= '0;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
			tick  <= 1'b0;
		end
	end

	tick_single_a: assert property (@(posedge clk) disable iff (sys_rst)
		tick |=> !tick) else $error("tick longer than one cycle");

endmodule

//--- hw/acs_delay_timer.sv
`timescale 1ns/1ps
module acs_delay_timer
	import acs_pkg::*;
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             sys_rst,
	// count enable
	input  wire logic             tick,
	// load
	input  wire logic             load,
	input  wire logic [TMR_W-1:0] load_val,
	// status
	output logic                  expired
);

	logic [TMR_W-1:0] cnt_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= load_val;
		end else if (tick && cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	assign expired = (cnt_q == '0);

	count_down_a: assert property (@(posedge clk) disable iff (sys_rst)
		!load && tick && !expired |=> cnt_q == $past(cnt_q) - 1'b1)
		else $error("delay count did not step");

endmodule

//--- dv/acs_core_model.sv
`timescale 1ns/1ps
module acs_core_model
	import acs_pkg::*;
(
	// sequencer side
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             core_clk_en,
	input  wire logic             core_cal_req,
	output logic                  core_cal_done,
	input  wire logic             core_conv_req,
	input  wire logic [CH_W-1:0]  core_channel,
	output logic                  core_conv_done,
	output logic      [RES_W-1:0] core_result,
	// scenario control
	input  wire logic             slow,
	input  wire logic [5:0]       base
);
	logic [2:0] cnt_q;

	// ==========================================================
	// core answers move only on ticks
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_q          <= 3'h0;
			core_cal_done  <= 1'b0;
			core_conv_done <= 1'b0;
			core_result    <= 10'h3FF;
		end else if (core_clk_en) begin
			if (core_cal_req) begin
				cnt_q <= cnt_q + 3'h1;
				if (cnt_q == 3'h3) begin
					core_cal_done <= 1'b1;
					cnt_q         <= 3'h0;
				end
			end else if (core_conv_req && core_conv_done) begin
				// taken at this tick: drop so a next slot cannot reuse it
				core_conv_done <= 1'b0;
				core_result    <= ~core_result;
			end else if (core_conv_req) begin
				cnt_q <= cnt_q + 3'h1;
				if (cnt_q >= (slow ? 3'h3 : 3'h0)) begin
					core_conv_done <= 1'b1;
					core_result    <= {core_channel, base};
					cnt_q          <= 3'h0;
				end
			end else begin
				// stale data keeps toggling so it never looks valid
				core_conv_done <= 1'b0;
				cnt_q          <= 3'h0;
				core_result    <= ~core_result;
			end
		end
	end
endmodule

//--- dv/adc_conversion_sequencer_bench.sv
`timescale 1ns/1ps
module adc_conversion_sequencer_bench
	import acs_pkg::*;
;
	localparam logic [31:0] C_EN = 32'h1 << CTRL_EN_BIT;
	localparam logic [31:0] C_ST = 32'h1 << CTRL_START_BIT;
	localparam logic [31:0] C_CT = 32'h1 << CTRL_CONT_BIT;
	localparam logic [31:0] C_FZ = 32'h1 << CTRL_FREEZE_BIT;
	localparam logic [31:0] C_MK = 32'h1 << CTRL_MASK_BIT;
	localparam int          S    = STEP_TICKS * ADC_DIV;

	logic              clk, sys_rst, reg_wr, reg_rd, slow;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata;
	logic              core_clk_en, core_power_en, core_cal_req, core_cal_done;
	logic              core_conv_req, core_conv_done, conv_done_int;
	logic [CH_W-1:0]   core_channel;
	logic [RES_W-1:0]  core_result;
	logic [5:0]        base;
	logic [3:0]        chs [8];
	int                failures, cmp_count, k, a0, t0, f0, g0, f1, g1;
	int                cyc = 0;
	int                n = 0;
	int                at_q [1024];

	acs_sequencer i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.core_clk_en(core_clk_en), .core_power_en(core_power_en),
		.core_cal_req(core_cal_req), .core_cal_done(core_cal_done),
		.core_conv_req(core_conv_req), .core_channel(core_channel),
		.core_conv_done(core_conv_done), .core_result(core_result),
		.conv_done_int(conv_done_int));
	acs_core_model i_core (.clk(clk), .sys_rst(sys_rst), .core_clk_en(core_clk_en),
		.core_cal_req(core_cal_req), .core_cal_done(core_cal_done),
		.core_conv_req(core_conv_req), .core_channel(core_channel),
		.core_conv_done(core_conv_done), .core_result(core_result),
		.slow(slow), .base(base));

	// ==========================================================
	// clock and completion monitor
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (core_clk_en === 1'b1 && core_conv_req === 1'b1 && core_conv_done === 1'b1) begin
			at_q[n % 1024] <= cyc;
			n <= n + 1;
		end
	end

	// ==========================================================
	// helpers
	function automatic logic [9:0] res(logic [3:0] c, logic [5:0] b);
		return (c == CHAN_RESERVED) ? 10'h000 : {c, b};
	endfunction
	function automatic logic [31:0] pk(logic [9:0] a, logic [9:0] b);
		return {6'h00, b, 6'h00, a};
	endfunction
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic rng(input int v, input int lo, input int hi);
		cmp_count++;
		if (v < lo || v > hi) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h..%h", $time, v, lo, hi);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		// let the write settle before anyone samples outputs
		#1;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		logic [DATA_W-1:0] d;
		rd(a, d);
		chk(d, e);
	endtask
	task automatic poll(input int b, input logic v);
		logic [DATA_W-1:0] d;
		int i;
		for (i = 0; i < 20000; i++) begin
			rd(REG_STATUS, d);
			if (d[b] === v)
				break;
		end
		if (i == 20000) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, d[b], v);
			complete_run();
		end
	endtask
	task automatic wconv(input int m);
		int i;
		for (i = 0; i < 50000 && n < m; i++)
			@(posedge clk);
		if (n < m) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, n, m);
			complete_run();
		end
	endtask
	// run a sequence, wait for m completions, then stop it cleanly
	task automatic meas(input logic [31:0] dly, input logic [31:0] ctl, input int m,
		output int first, output int t);
		wr(REG_DELAY, dly);
		first = n;
		t = cyc;
		wr(REG_CTRL, ctl);
		wconv(first + m);
		poll(STAT_DONE_BIT, 1'b1);
		// single runs must not linger in a post delay
		if (!ctl[CTRL_CONT_BIT])
			rchk(REG_STATUS, 32'h0000_0005);
		wr(REG_CTRL, C_EN);
		poll(STAT_BUSY_BIT, 1'b0);
		wr(REG_STATUS, 32'h0000_0001);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = '0; reg_wdata = '0;
		slow = 1'b0; base = 6'h15; failures = 0; cmp_count = 0;
		chs = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8};
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		rchk(REG_CTRL, 32'h0);
		rchk(REG_DELAY, 32'h0);
		rchk(REG_RESULT0, 32'h0);
		rchk(4'hF, 32'h0);
		chk(core_power_en, 1'b0);
		poll(STAT_CAL_BIT, 1'b1);
		wr(REG_DELAY, 32'h0000_0FA5);
		rchk(REG_DELAY, 32'h0000_0FA5);
		$display("reset and access test done");

		wr(REG_SEL_LO, 32'h0000_9F61);
		a0 = n;
		meas(32'h0, C_EN | C_ST | (32'h2 << CTRL_STOP_LSB), 2, a0, t0);
		chk(n - a0, 2);
		rchk(REG_RESULT0, pk(res(4'h1, 6'h15), 10'h000));
		rchk(REG_RESULT1, pk(res(4'hF, 6'h15), 10'h000));
		rchk(REG_CTRL, C_EN);
		$display("single sequence test done");

		slow = 1'b1;
		base = 6'h2A;
		wr(REG_SEL_LO, 32'h0000_3210);
		wr(REG_SEL_HI, 32'h0000_8754);
		a0 = n;
		wr(REG_CTRL, C_EN | C_ST | C_MK | (32'h7 << CTRL_STOP_LSB));
		poll(STAT_DONE_BIT, 1'b1);
		chk(n - a0, 8);
		for (k = 0; k < 4; k++)
			rchk(REG_RESULT0 + k, pk(res(chs[2*k], 6'h2A), res(chs[2*k+1], 6'h2A)));
		chk(conv_done_int, 1'b0);
		wr(REG_CTRL, C_EN);
		chk(conv_done_int, 1'b1);
		wr(REG_STATUS, 32'h0000_0001);
		chk(conv_done_int, 1'b0);
		slow = 1'b0;
		$display("full sequence and mask test done");

		meas(32'h0, C_EN | C_ST | (32'h1 << CTRL_STOP_LSB), 2, a0, t0);
		f0 = at_q[a0 % 1024] - t0;
		g0 = at_q[(a0 + 1) % 1024] - at_q[a0 % 1024];
		meas(32'h0F1F, C_EN | C_ST | (32'h1 << CTRL_STOP_LSB), 2, a0, t0);
		f1 = at_q[a0 % 1024] - t0;
		g1 = at_q[(a0 + 1) % 1024] - at_q[a0 % 1024];
		rng(f0, SYNC_TICKS * ADC_DIV, (SYNC_TICKS + 6) * ADC_DIV);
		rng(f1 - f0, 15 * S - ADC_DIV, 15 * S + ADC_DIV);
		rng(g1 - g0, S - ADC_DIV, S + ADC_DIV);
		$display("delay timing test done");

		meas(32'h0, C_EN | C_ST | C_CT, 3, a0, t0);
		g0 = at_q[(a0 + 2) % 1024] - at_q[(a0 + 1) % 1024];
		meas(32'h100, C_EN | C_ST | C_CT, 3, a0, t0);
		g1 = at_q[(a0 + 2) % 1024] - at_q[(a0 + 1) % 1024];
		rng(g1 - g0, S - ADC_DIV, S + ADC_DIV);
		wr(REG_SEL_LO, 32'h0000_0003);
		wr(REG_DELAY, 32'h0);
		base = 6'h11;
		a0 = n;
		wr(REG_CTRL, C_EN | C_ST | C_CT);
		wconv(a0 + 2);
		rchk(REG_RESULT0, pk(res(4'h3, 6'h11), res(4'h1, 6'h2A)));
		wr(REG_CTRL, C_EN | C_CT | C_FZ);
		base <= 6'h22;
		a0 = n;
		wconv(a0 + 3);
		rchk(REG_RESULT0, pk(res(4'h3, 6'h11), res(4'h1, 6'h2A)));
		wr(REG_CTRL, C_EN | C_CT);
		a0 = n;
		wconv(a0 + 2);
		rchk(REG_RESULT0, pk(res(4'h3, 6'h22), res(4'h1, 6'h2A)));
		wr(REG_CTRL, C_EN);
		poll(STAT_BUSY_BIT, 1'b0);
		wr(REG_STATUS, 32'h0000_0001);
		$display("continuous and freeze test done");

		wr(REG_CTRL, 32'h0);
		wr(REG_CTRL, C_ST);
		a0 = n;
		repeat (200) @(posedge clk);
		chk(n - a0, 0);
		chk(core_power_en, 1'b0);
		wr(REG_CTRL, C_EN);
		poll(STAT_DONE_BIT, 1'b1);
		chk(n - a0, 1);
		chk(core_power_en, 1'b1);
		wr(REG_STATUS, 32'h0000_0001);
		slow = 1'b1;
		a0 = n;
		wr(REG_CTRL, C_EN | C_ST | (32'h7 << CTRL_STOP_LSB));
		wconv(a0 + 1);
		wr(REG_CTRL, 32'h0);
		repeat (200) @(posedge clk);
		rchk(REG_STATUS, 32'h0000_0004);
		chk(conv_done_int, 1'b0);
		$display("enable and abort test done");
		complete_run();
	end
endmodule
